// File: logic/pfv_config_top.sv
// Phase, frequency and input-voltage configuration behind the serial link
`timescale 1ns/1ps
module pfv_config_top #(
  parameter logic [6:0] DEV_ADDR = 7'h4F
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sync_pin,
  input wire logic [1:0] run_pin,
  input wire logic [1:0] chan_cmd_on,
  input wire logic [15:0] vin_meas,
  input wire logic pll_locked,
  input wire logic clear_faults,
  output logic sync_fall,
  output logic share_clk_out,
  output logic share_clk_oe,
  output pfv_pkg::pfv_cfg_t cfg,
  output pfv_pkg::pfv_stat_t stat
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_ff;
  logic rst_n;
  logic [4:0] pin_m, pin_s;
  logic [2:0] pin_d;
  logic scl_s, scl_d, sda_s, sda_d, sync_s, sync_d;
  logic [1:0] run_s;

  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      rst_ff <= 2'h0;
    else
      rst_ff <= {rst_ff[0], 1'b1};
  assign rst_n = rst_ff[1];

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      // Link lines reset to their idle high level: no false edge
      pin_m <= 5'h18;
      pin_s <= 5'h18;
      pin_d <= 3'h6;
    end
    else
    begin
      pin_m <= {scl_pin, sda_in, sync_pin, run_pin};
      pin_s <= pin_m;
      pin_d <= pin_s[4:2];
    end
  assign {scl_s, sda_s, sync_s, run_s} = pin_s;
  assign {scl_d, sda_d, sync_d} = pin_d;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      sync_fall <= 1'b0;
    else
      sync_fall <= sync_d & ~sync_s;

  chk_sync_fall_edge: assert property (
    sync_fall |-> $past(sync_s, 2) && !$past(sync_s))
    else $error("sync_fall without a falling sync edge");

  // ==========================================================
  // Command decode helpers
  logic scl_rise, scl_fall, start, stop, busy;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  // Running means a run pin high with its channel commanded on
  assign busy = |(run_s & chan_cmd_on);

  function automatic logic [3:0] cmd_idx(input logic [7:0] c);
    case (c)
      pfv_pkg::CMD_FREQ: cmd_idx = {1'b1, pfv_pkg::IDX_FREQ};
      pfv_pkg::CMD_VON: cmd_idx = {1'b1, pfv_pkg::IDX_VON};
      pfv_pkg::CMD_VOFF: cmd_idx = {1'b1, pfv_pkg::IDX_VOFF};
      pfv_pkg::CMD_VOV: cmd_idx = {1'b1, pfv_pkg::IDX_VOV};
      pfv_pkg::CMD_VUV: cmd_idx = {1'b1, pfv_pkg::IDX_VUV};
      pfv_pkg::CMD_PHASE: cmd_idx = {1'b1, pfv_pkg::IDX_PHASE};
      pfv_pkg::CMD_RVIN: cmd_idx = {1'b1, pfv_pkg::IDX_RVIN};
      default: cmd_idx = 4'h0;
    endcase
  endfunction

  function automatic logic [10:0] freq_look(input pfv_pkg::pfv_word_t w);
    freq_look = 11'h000;
    for (int i = 0; i < pfv_pkg::NFREQ; i++)
      if (w == pfv_pkg::FREQ_CODE[i])
        freq_look = {1'b1, pfv_pkg::FREQ_KHZ[i]};
  endfunction

  // Linear word to unsigned fixed point with 16 fraction bits
  function automatic logic [41:0] l11_fix(input pfv_pkg::pfv_word_t w);
    logic [41:0] m;
    m = w[10] ? 42'h0 : {32'h0, w[9:0]};
    l11_fix = m << {~w[15], w[14:11]};
  endfunction

  // ==========================================================
  // Serial link slave
  pfv_pkg::pfv_state_t state;
  pfv_pkg::pfv_word_t regs [pfv_pkg::NREG];
  logic [3:0] bit_cnt;
  logic [7:0] shreg, cmd;
  logic [1:0] nbytes;
  logic [15:0] wbuf;
  logic rd_mode, rd_idx, ack_ok, mnack, refused, wr_seen;
  logic [2:0] idx;
  logic [1:0] need;
  logic guarded, busy_evt, commit, byte_end;
  pfv_pkg::pfv_word_t rd_word;

  logic [3:0] cmd_dec, sh_dec;
  assign cmd_dec = cmd_idx(cmd);
  assign sh_dec = cmd_idx(shreg);
  assign idx = cmd_dec[2:0];
  assign guarded = (idx == pfv_pkg::IDX_PHASE) | (idx == pfv_pkg::IDX_FREQ);
  // Phase byte takes one data byte, every other word exactly two
  assign need = (idx == pfv_pkg::IDX_PHASE) ? 2'h1 : 2'h2;
  assign rd_word = regs[idx];
  assign byte_end = scl_fall & (state == pfv_pkg::ST_WR) & (bit_cnt == 4'h8);
  assign busy_evt = byte_end & guarded & busy;
  assign commit = (start | stop) & wr_seen & ~refused & (nbytes == need);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= pfv_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      nbytes <= 2'h0;
      wbuf <= 16'h0000;
      rd_mode <= 1'b0;
      rd_idx <= 1'b0;
      ack_ok <= 1'b0;
      mnack <= 1'b0;
      refused <= 1'b0;
      wr_seen <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start | stop)
    begin
      state <= start ? pfv_pkg::ST_ADDR : pfv_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      wr_seen <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state == pfv_pkg::ST_MACK)
        mnack <= sda_s;
      else if (state == pfv_pkg::ST_ADDR || state == pfv_pkg::ST_CMD ||
               state == pfv_pkg::ST_WR)
      begin
        shreg <= {shreg[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
    else if (scl_fall)
      case (state)
        pfv_pkg::ST_ADDR:
          if (bit_cnt == 4'h8)
          begin
            if (shreg[7:1] == DEV_ADDR)
            begin
              sda_oe <= 1'b1;
              rd_mode <= shreg[0];
              state <= pfv_pkg::ST_ACKA;
            end
            else
              state <= pfv_pkg::ST_IDLE;
          end
        pfv_pkg::ST_ACKA:
          if (rd_mode)
          begin
            state <= pfv_pkg::ST_RD;
            rd_idx <= 1'b0;
            sda_oe <= ~rd_word[7];
            bit_cnt <= 4'h1;
          end
          else
          begin
            state <= pfv_pkg::ST_CMD;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            nbytes <= 2'h0;
            refused <= 1'b0;
          end
        pfv_pkg::ST_CMD:
          if (bit_cnt == 4'h8)
          begin
            cmd <= shreg;
            ack_ok <= sh_dec[3];
            sda_oe <= sh_dec[3];
            state <= pfv_pkg::ST_ACKC;
          end
        pfv_pkg::ST_ACKC:
        begin
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
          state <= ack_ok ? pfv_pkg::ST_WR : pfv_pkg::ST_IDLE;
        end
        pfv_pkg::ST_WR:
          if (bit_cnt == 4'h8)
          begin
            wr_seen <= 1'b1;
            state <= pfv_pkg::ST_ACKC;
            if (guarded & busy)
            begin
              refused <= 1'b1;
              ack_ok <= 1'b0;
              sda_oe <= 1'b0;
            end
            else if (nbytes < need)
            begin
              if (nbytes == 2'h0)
                wbuf[7:0] <= shreg;
              else
                wbuf[15:8] <= shreg;
              nbytes <= nbytes + 2'h1;
              sda_oe <= 1'b1;
            end
            else
            begin
              refused <= 1'b1;
              ack_ok <= 1'b0;
              sda_oe <= 1'b0;
            end
          end
        pfv_pkg::ST_RD:
          if (bit_cnt == 4'h8)
          begin
            sda_oe <= 1'b0;
            state <= pfv_pkg::ST_MACK;
          end
          else
          begin
            sda_oe <= rd_idx ? ~rd_word[4'hF - bit_cnt]
                             : ~rd_word[4'h7 - bit_cnt];
            bit_cnt <= bit_cnt + 4'h1;
          end
        pfv_pkg::ST_MACK:
          if (mnack)
            state <= pfv_pkg::ST_IDLE;
          else
          begin
            state <= pfv_pkg::ST_RD;
            rd_idx <= ~rd_idx;
            sda_oe <= rd_idx ? ~rd_word[7] : ~rd_word[15];
            bit_cnt <= 4'h1;
          end
        default:
          state <= pfv_pkg::ST_IDLE;
      endcase

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;

  sequence s_busy_byte;
    busy_evt;
  endsequence
  chk_busy_nack: assert property (
    s_busy_byte |=> !sda_oe && stat.busy_fault && refused)
    else $error("busy write was acknowledged or not flagged");

  sequence s_third_byte;
    byte_end && nbytes == need;
  endsequence
  chk_word_len: assert property (
    s_third_byte |=> !sda_oe && refused)
    else $error("extra data byte acknowledged");

  // ==========================================================
  // Register storage
  logic [10:0] fnew;
  logic freq_chg;
  assign fnew = freq_look(wbuf);
  assign freq_chg = commit & (idx == pfv_pkg::IDX_FREQ) & fnew[10] &
                    (wbuf != regs[pfv_pkg::IDX_FREQ]);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < pfv_pkg::NREG; i++)
        regs[i] <= pfv_pkg::RST_VAL[i];
    end
    else if (commit)
      case (idx)
        pfv_pkg::IDX_PHASE:
          regs[idx] <= {8'h00, wbuf[7:3], (wbuf[2:0] == pfv_pkg::PH_RSVD)
            ? regs[idx][2:0] : wbuf[2:0]};
        pfv_pkg::IDX_FREQ:
          if (fnew[10])
            regs[idx] <= wbuf;
        default:
          regs[idx] <= wbuf;
      endcase

  chk_refused_keep: assert property (
    (start || stop) && refused |=> $stable(regs[pfv_pkg::IDX_PHASE]) &&
      $stable(regs[pfv_pkg::IDX_FREQ]))
    else $error("refused write changed a register");
  chk_phase_rsvd: assert property (
    commit && idx == pfv_pkg::IDX_PHASE && wbuf[2:0] == pfv_pkg::PH_RSVD
      |=> $stable(regs[pfv_pkg::IDX_PHASE][2:0]))
    else $error("reserved phase code was stored");

  // ==========================================================
  // Decoded configuration outputs
  logic [7:0] pcfg;
  logic [10:0] fcur;
  assign pcfg = regs[pfv_pkg::IDX_PHASE][7:0];
  assign fcur = freq_look(regs[pfv_pkg::IDX_FREQ]);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      cfg <= '0;
    else
    begin
      cfg.gain_x <= pfv_pkg::GAIN_X[pcfg[pfv_pkg::GAIN_LSB +: 2]];
      cfg.range_mv <= pfv_pkg::RANGE_MV[pcfg[pfv_pkg::GAIN_LSB +: 2]];
      cfg.share_en <= pcfg[pfv_pkg::SHARE_BIT];
      cfg.ph0_deg <= pfv_pkg::PH0_DEG[pcfg[pfv_pkg::PH_LSB +: 3]];
      cfg.ph1_deg <= pfv_pkg::PH1_DEG[pcfg[pfv_pkg::PH_LSB +: 3]];
      cfg.ext_osc <= regs[pfv_pkg::IDX_FREQ] == pfv_pkg::FREQ_EXT;
      cfg.freq_khz <= fcur[9:0];
    end

  chk_gain_map: assert property (
    (pcfg[6:5] == 2'h2) [*2] |-> cfg.gain_x == 4'h8 && cfg.range_mv == 6'h05)
    else $error("gain code 10b not decoded as 8x");

  // ==========================================================
  // Input voltage supervision and status
  logic [41:0] vin_fx;
  logic vin_ok, powered_once, busy_fault, pll_unlock, ov_fault, uv_warn;
  assign vin_fx = l11_fix(vin_meas);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      vin_ok <= 1'b0;
      powered_once <= 1'b0;
    end
    else
    begin
      if (vin_fx >= l11_fix(regs[pfv_pkg::IDX_VON]))
        vin_ok <= 1'b1;
      else if (vin_fx <= l11_fix(regs[pfv_pkg::IDX_VOFF]))
        vin_ok <= 1'b0;
      powered_once <= powered_once | vin_ok;
    end

  // Released only once input is good; otherwise power-up only
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      share_clk_oe <= 1'b1;
    else if (pcfg[pfv_pkg::SHARE_BIT])
      share_clk_oe <= ~vin_ok;
    else
      share_clk_oe <= ~powered_once;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      share_clk_out <= 1'b0;
    else
      share_clk_out <= 1'b0;

  // Event set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      busy_fault <= 1'b0;
      pll_unlock <= 1'b0;
      ov_fault <= 1'b0;
      uv_warn <= 1'b0;
    end
    else
    begin
      if (busy_evt)
        busy_fault <= 1'b1;
      else if (clear_faults)
        busy_fault <= 1'b0;
      if (freq_chg)
        pll_unlock <= 1'b1;
      else if (pll_locked)
        pll_unlock <= 1'b0;
      if (vin_fx > l11_fix(regs[pfv_pkg::IDX_VOV]))
        ov_fault <= 1'b1;
      else if (clear_faults)
        ov_fault <= 1'b0;
      uv_warn <= powered_once & (|chan_cmd_on) &
        (vin_fx < l11_fix(regs[pfv_pkg::IDX_VUV]));
    end
  assign stat = {busy_fault, pll_unlock, ov_fault, uv_warn, vin_ok};

  chk_share_hold: assert property (
    pcfg[pfv_pkg::SHARE_BIT] && !vin_ok |=> share_clk_oe)
    else $error("share clock released before input good");
  chk_share_free: assert property (
    !pcfg[pfv_pkg::SHARE_BIT] && powered_once |=> !share_clk_oe)
    else $error("share clock pulled low after power-up");
  chk_freq_unlock: assert property (
    freq_chg |=> stat.pll_unlock)
    else $error("frequency change did not flag unlock");
  chk_ov_fault: assert property (
    vin_fx > l11_fix(regs[pfv_pkg::IDX_VOV]) |=> stat.vin_ov_fault)
    else $error("overvoltage not flagged");
  chk_conv_window: assert property (
    vin_fx <= l11_fix(regs[pfv_pkg::IDX_VOFF]) &&
      vin_fx < l11_fix(regs[pfv_pkg::IDX_VON]) |=> !stat.conv_en)
    else $error("conversion left on below turn-off threshold");

endmodule // pfv_config_top

// File: logic/pfv_pkg.sv
// Package: command codes, reset values, tables and types for the config block
package pfv_pkg;

  // ==========================================================
  // Command codes and register indices
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_VON = 8'h35;
  localparam logic [7:0] CMD_VOFF = 8'h36;
  localparam logic [7:0] CMD_VOV = 8'h55;
  localparam logic [7:0] CMD_VUV = 8'h58;
  localparam logic [7:0] CMD_PHASE = 8'hF5;
  localparam logic [7:0] CMD_RVIN = 8'hF7;
  localparam int NREG = 7;
  localparam logic [2:0] IDX_FREQ = 3'h0;
  localparam logic [2:0] IDX_VON = 3'h1;
  localparam logic [2:0] IDX_VOFF = 3'h2;
  localparam logic [2:0] IDX_VOV = 3'h3;
  localparam logic [2:0] IDX_VUV = 3'h4;
  localparam logic [2:0] IDX_PHASE = 3'h5;
  localparam logic [2:0] IDX_RVIN = 3'h6;

  typedef logic [15:0] pfv_word_t;
  localparam pfv_word_t RST_VAL [NREG] = '{16'hFB52, 16'hCB40, 16'hCB00,
    16'hD3E0, 16'hCB26, 16'h0010, 16'h03E8};

  // ==========================================================
  // Phase and gain byte layout
  localparam int PH_LSB = 0;
  localparam int SHARE_BIT = 4;
  localparam int GAIN_LSB = 5;
  localparam logic [2:0] PH_RSVD = 3'h7;
  localparam logic [8:0] PH0_DEG [8] = '{9'h000, 9'h05A, 9'h000, 9'h000,
    9'h078, 9'h03C, 9'h078, 9'h000};
  localparam logic [8:0] PH1_DEG [8] = '{9'h0B4, 9'h10E, 9'h0F0, 9'h078,
    9'h0F0, 9'h0F0, 9'h12C, 9'h000};
  localparam logic [3:0] GAIN_X [4] = '{4'h2, 4'h4, 4'h8, 4'h0};
  localparam logic [5:0] RANGE_MV [4] = '{6'h32, 6'h14, 6'h05, 6'h00};

  // ==========================================================
  // Frequency word table, first entry is external oscillator
  localparam int NFREQ = 9;
  localparam pfv_word_t FREQ_CODE [NFREQ] = '{16'h0000, 16'hF3E8,
    16'hFABC, 16'hFB52, 16'hFBE8, 16'h023F, 16'h028A, 16'h02EE, 16'h03E8};
  localparam logic [9:0] FREQ_KHZ [NFREQ] = '{10'h000, 10'h0FA, 10'h15E,
    10'h1A9, 10'h1F4, 10'h23F, 10'h28A, 10'h2EE, 10'h3E8};
  localparam pfv_word_t FREQ_EXT = 16'h0000;

  // ==========================================================
  // Serial link states, Gray coded along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ACKA = 3'h3, ST_CMD = 3'h2,
    ST_ACKC = 3'h6, ST_WR = 3'h7, ST_RD = 3'h5, ST_MACK = 3'h4
  } pfv_state_t;

  typedef struct packed {
    logic [3:0] gain_x;
    logic [5:0] range_mv;
    logic share_en;
    logic [8:0] ph0_deg;
    logic [8:0] ph1_deg;
    logic ext_osc;
    logic [9:0] freq_khz;
  } pfv_cfg_t;

  typedef struct packed {
    logic busy_fault;
    logic pll_unlock;
    logic vin_ov_fault;
    logic vin_uv_warn;
    logic conv_en;
  } pfv_stat_t;

endpackage

// File: bench/pfv_host_model.sv
// Host side model issuing configuration commands over the two-wire link
`timescale 1ns/1ps
module pfv_host_model #(
  parameter logic [6:0] ADDR = 7'h4F
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ==========================================================
  // Bit level, 64 ns period; clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Also serves as repeated start: data released before clock rises
  task automatic start();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask

  // Long tail leaves room for stop detection and the commit
  task automatic stop();
    sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #64;
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic mack,
    output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(!mack, r);
    ack = !r;
  endtask

  // ==========================================================
  // Command level
  task automatic write_cmd(input logic [7:0] cmd, input logic [23:0] d,
    input int n, output logic [4:0] acks);
    logic [7:0] rx;
    logic a;
    acks = 5'h00;
    start();
    xfer({ADDR, 1'b0}, 1'b0, rx, acks[0]);
    xfer(cmd, 1'b0, rx, acks[1]);
    for (int i = 0; i < n; i++)
    begin
      xfer(d[8*i+:8], 1'b0, rx, a);
      acks[2+i] = a;
    end
    stop();
  endtask

  // Word read, low byte first, host refuses the last byte
  task automatic read_cmd(input logic [7:0] cmd, output logic [15:0] d,
    output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b0, rx, a0);
    xfer(cmd, 1'b0, rx, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b0, rx, a2);
    xfer(8'hFF, 1'b1, rx, ok);
    d[7:0] = rx;
    xfer(8'hFF, 1'b0, rx, ok);
    d[15:8] = rx;
    ok = a0 & a1 & a2;
    stop();
  endtask
endmodule // pfv_host_model

// File: bench/pfv_config_top_tb.sv
// Self-checking testbench for the configuration block
`timescale 1ns/1ps
module pfv_config_top_tb;
  logic core_clk = 1'b0;
  logic arst_n, scl, sda_low, sync_pin, pll_locked, clear_faults;
  logic sda_out, sda_oe, sync_fall, share_clk_out, share_clk_oe;
  logic [1:0] run_pin, chan_cmd_on;
  logic [15:0] vin_meas;
  pfv_pkg::pfv_cfg_t cfg;
  pfv_pkg::pfv_stat_t stat;
  wire sda = !sda_low && (sda_oe ? sda_out : 1'b1);
  int miscompares = 0;
  int n_checks = 0;

  always #2.5 core_clk = !core_clk;

  pfv_config_top i_pfv_config_top (.core_clk(core_clk), .arst_n(arst_n),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sync_pin(sync_pin), .run_pin(run_pin), .chan_cmd_on(chan_cmd_on),
    .vin_meas(vin_meas), .pll_locked(pll_locked),
    .clear_faults(clear_faults), .sync_fall(sync_fall),
    .share_clk_out(share_clk_out), .share_clk_oe(share_clk_oe),
    .cfg(cfg), .stat(stat));

  pfv_host_model i_pfv_host_model (.scl(scl), .sda_low(sda_low),
    .sda(sda));

  // ==========================================================
  // Helpers
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [23:0] d,
    input int n, input logic [4:0] exp);
    logic [4:0] a;
    i_pfv_host_model.write_cmd(c, d, n, a);
    idle(2);
    chk(16'(a), 16'(exp), "ack");
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_pfv_host_model.read_cmd(c, d, ok);
    idle(2);
    chk(16'(ok), 16'h0001, "read ack");
    chk(d, exp, "read");
  endtask

  task automatic setv(input logic [15:0] v, input logic [1:0] exp);
    vin_meas = v;
    idle(3);
    chk(16'({stat.conv_en, share_clk_oe}), 16'(exp), "conv/share");
  endtask

  task automatic pulse_clear();
    clear_faults = 1'b1;
    idle(1);
    clear_faults = 1'b0;
    idle(2);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    logic [7:0] c [7] = '{8'h33, 8'h35, 8'h36, 8'h55, 8'h58, 8'hF5, 8'hF7};
    logic [15:0] v [7] = '{16'hFB52, 16'hCB40, 16'hCB00, 16'hD3E0,
      16'hCB26, 16'h0010, 16'h03E8};
    chk(16'(cfg.freq_khz), 16'h01A9, "freq");
    chk(16'({cfg.gain_x, cfg.range_mv}), 16'h0B2, "gain");
    chk(16'({cfg.ph0_deg, cfg.ph1_deg}), 16'h00B4, "phase");
    for (int i = 0; i < 7; i++)
      rd(c[i], v[i]);
    wr(8'hF7, 24'h001234, 2, 5'h0F);
    rd(8'hF7, 16'h1234);
    wr(8'h58, 24'h00CB20, 2, 5'h0F);
    rd(8'h58, 16'hCB20);
    wr(8'h20, 24'h000000, 0, 5'h01);
  endtask

  task automatic t_phase();
    logic [8:0] p0 [7] = '{9'h000, 9'h05A, 9'h000, 9'h000, 9'h078,
      9'h03C, 9'h078};
    logic [8:0] p1 [7] = '{9'h0B4, 9'h10E, 9'h0F0, 9'h078, 9'h0F0,
      9'h0F0, 9'h12C};
    logic [9:0] g [4] = '{10'h0B2, 10'h114, 10'h205, 10'h000};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'hF5, {16'h0000, 1'b0, 2'(i % 4), 2'h2, 3'(i)}, 1, 5'h07);
      chk(16'(cfg.ph0_deg), 16'(p0[i]), "ph0");
      chk(16'(cfg.ph1_deg), 16'(p1[i]), "ph1");
      chk(16'({cfg.gain_x, cfg.range_mv}), 16'(g[i % 4]), "gain");
    end
    wr(8'hF5, 24'h000037, 1, 5'h07);
    chk(16'({cfg.ph0_deg, cfg.ph1_deg}), 16'hF12C, "keep");
    chk(16'({cfg.gain_x, cfg.range_mv}), 16'h114, "gain");
    wr(8'hF5, 24'h001037, 2, 5'h07);
  endtask

  task automatic t_freq();
    logic [15:0] fc [9] = '{16'h0000, 16'hF3E8, 16'hFABC, 16'hFB52,
      16'hFBE8, 16'h023F, 16'h028A, 16'h02EE, 16'h03E8};
    logic [9:0] fk [9] = '{10'h000, 10'h0FA, 10'h15E, 10'h1A9, 10'h1F4,
      10'h23F, 10'h28A, 10'h2EE, 10'h3E8};
    for (int i = 0; i < 9; i++)
    begin
      wr(8'h33, 24'(fc[i]), 2, 5'h0F);
      chk(16'({cfg.ext_osc, cfg.freq_khz}), {5'h00, i == 0, fk[i]},
        "freq");
      if (i == 0)
      begin
        chk(16'(stat.pll_unlock), 16'h0001, "unlock");
        pll_locked = 1'b1;
        idle(2);
        chk(16'(stat.pll_unlock), 16'h0000, "relock");
      end
    end
    wr(8'h33, 24'h001234, 2, 5'h0F);
    wr(8'h33, 24'h00F3E8, 3, 5'h0F);
    chk(16'(cfg.freq_khz), 16'h03E8, "kept");
  endtask

  task automatic t_busy();
    run_pin = 2'h1;
    chan_cmd_on = 2'h2;
    wr(8'hF5, 24'h000003, 1, 5'h07);
    chk(16'(cfg.ph1_deg), 16'h0078, "free");
    chan_cmd_on = 2'h1;
    wr(8'hF5, 24'h000010, 1, 5'h03);
    chk(16'({stat.busy_fault, cfg.ph1_deg}), 16'h0278, "busy");
    pulse_clear();
    chk(16'(stat.busy_fault), 16'h0000, "clear");
    wr(8'h33, 24'h00FB52, 2, 5'h03);
    chk(16'({stat.busy_fault, cfg.freq_khz}), 16'h07E8, "busy");
    run_pin = 2'h0;
    chan_cmd_on = 2'h0;
    pulse_clear();
  endtask

  task automatic t_vin();
    // Busy scenario left the share bit cleared; enable it again
    wr(8'hF5, 24'h000010, 1, 5'h07);
    chk(16'(cfg.share_en), 16'h0001, "share en");
    setv(16'h0000, 2'h1);
    setv(16'hCB30, 2'h1);
    setv(16'hCB50, 2'h2);
    setv(16'hCB30, 2'h2);
    setv(16'hCAF0, 2'h1);
    wr(8'hF5, 24'h000000, 1, 5'h07);
    chk(16'(cfg.share_en), 16'h0000, "share dis");
    setv(16'hCB50, 2'h2);
    setv(16'hCAF0, 2'h0);
    chan_cmd_on = 2'h1;
    idle(3);
    chk(16'(stat.vin_uv_warn), 16'h0001, "uv");
    chan_cmd_on = 2'h0;
    setv(16'hD3F0, 2'h2);
    setv(16'hCB50, 2'h2);
    chk(16'(stat.vin_ov_fault), 16'h0001, "ov");
    pulse_clear();
    chk(16'(stat.vin_ov_fault), 16'h0000, "ov clear");
    wr(8'h55, 24'h001234, 3, 5'h0F);
    rd(8'h55, 16'hD3E0);
  endtask

  task automatic t_reset();
    arst_n = 1'b0;
    idle(2);
    chk(16'({sda_oe, share_clk_oe, share_clk_out, stat}), 16'h0040,
      "mid reset");
    arst_n = 1'b1;
    idle(8);
    chk(16'(cfg.freq_khz), 16'h01A9, "freq");
    rd(8'hF7, 16'h03E8);
  endtask

  task automatic t_sync();
    sync_pin = 1'b0;
    for (int k = 1; k < 6; k++)
    begin
      idle(1);
      chk(16'(sync_fall), 16'(k == 3), "fall");
    end
    sync_pin = 1'b1;
    for (int k = 1; k < 6; k++)
    begin
      idle(1);
      chk(16'(sync_fall), 16'h0000, "rise");
    end
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    arst_n = 1'b0;
    sync_pin = 1'b1;
    run_pin = 2'h0;
    chan_cmd_on = 2'h0;
    vin_meas = 16'h0000;
    pll_locked = 1'b0;
    clear_faults = 1'b0;
    idle(4);
    chk(16'({sda_oe, share_clk_oe}), 16'h0001, "reset");
    arst_n = 1'b1;
    idle(8);
    t_defaults();
    t_phase();
    t_freq();
    t_busy();
    t_vin();
    t_sync();
    t_reset();
    conclude();
  end

  // Run needs roughly 100 us of link traffic
  initial
  begin
    #400us;
    $display("mismatch at %0t: timeout", $time);
    miscompares++;
    conclude();
  end
endmodule // pfv_config_top_tb
